/* hdl/timer_two.sv */
/*
  second general timer: 16-bit counter with reload/capture register,
  control register, baud clock selection for the serial port.
  assumes a single 10 MHz clock and a register master using the plain port.
*/
// Behaviour
// - run bit clear: counter stops and holds its value unless a trigger fall reloads it
// - run bit set: counter advances on every tick of selected source
// - counter select clear: count peripheral clock cycles
// - counter select set: count falling edges of external count pin
// - either baud select set: trigger neither reloads nor captures, reload on overflow
// - capture select clear: reload on overflow, and on trigger fall if enabled
// - external flag requests interrupt while set, cleared only by software
// - control register resets to zero, bits singly set and cleared
`include "timer_two_defines.svh"
`default_nettype none
module timer_two
  import timer_two_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // pins
  input  wire logic       external_count_pin,
  input  wire logic       external_trigger_pin,
  // serial port and interrupt side
  input  wire logic       timer_one_overflow,
  input  wire logic       timer_irq_enable,
  output logic            timer_irq,
  output logic            rx_baud_tick,
  output logic            tx_baud_tick
);
  logic [7:0]    ctrl_q, ctrl_d;
  logic [15:0]   count_q, count_d;
  logic [15:0]   reload_q, reload_d;
  logic [7:0]    rdata_q, rdata_d;
  logic          irq_q, irq_d;
  logic          rxt_q, rxt_d, txt_q, txt_d;
  logic          cnt_fall, trig_fall;
  logic          tick, ovf, baud_mode;
  count_act_type act;

  // pins pass two flops before the edge detectors
  pin_sync u_count_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (external_count_pin),
    .level  (),
    .fall   (cnt_fall)
  );
  pin_sync u_trig_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (external_trigger_pin),
    .level  (),
    .fall   (trig_fall)
  );

  // source select and counter action
  always_comb begin
    baud_mode = ctrl_q[`T2_BIT_RXSEL] | ctrl_q[`T2_BIT_TXSEL];
    tick = ctrl_q[`T2_BIT_RUN] &
           (ctrl_q[`T2_BIT_CNTSEL] ? cnt_fall : 1'b1);
    ovf  = tick & (count_q == `T2_WORD_MAX);
    act  = tick ? act_inc : act_hold;
    if (ovf) begin
      act = act_reload;
    end
    // trigger only acts when enabled and when neither baud select is set
    if (ctrl_q[`T2_BIT_EXTEN] && trig_fall && !baud_mode) begin
      act = ctrl_q[`T2_BIT_CAPSEL] ? act_capture : act_reload;
    end
  end

  // counter, reload word and control register
  always_comb begin
    count_d  = count_q;
    reload_d = reload_q;
    ctrl_d   = ctrl_q;
    unique case (act)
      act_hold:    count_d = count_q;
      act_inc:     count_d = count_q + 16'h0001;
      act_reload:  count_d = reload_q;
      act_capture: begin
        count_d  = count_q + {15'h0000, tick};
        reload_d = count_q;
      end
    endcase
    if (wr) begin
      unique case (addr)
        `T2_ADDR_CONTROL:   ctrl_d = wdata;
        `T2_ADDR_BITSET:    ctrl_d = ctrl_q | wdata;
        `T2_ADDR_BITCLR:    ctrl_d = ctrl_q & ~wdata;
        `T2_ADDR_COUNT_LO:  count_d[7:0] = wdata;
        `T2_ADDR_COUNT_HI:  count_d[15:8] = wdata;
        `T2_ADDR_RELOAD_LO: reload_d[7:0] = wdata;
        `T2_ADDR_RELOAD_HI: reload_d[15:8] = wdata;
        default: ;
      endcase
    end
    // hardware sets win over a software clear in the same cycle
    if (ovf && !baud_mode) begin
      ctrl_d[`T2_BIT_OVF] = 1'b1;
    end
    if (ctrl_q[`T2_BIT_EXTEN] && trig_fall) begin
      ctrl_d[`T2_BIT_EXT] = 1'b1;
    end
  end

  // read data, interrupt and baud ticks
  always_comb begin
    rdata_d = `T2_BYTE_ZERO;
    if (rd) begin
      unique case (addr)
        `T2_ADDR_CONTROL:   rdata_d = ctrl_q;
        `T2_ADDR_COUNT_LO:  rdata_d = count_q[7:0];
        `T2_ADDR_COUNT_HI:  rdata_d = count_q[15:8];
        `T2_ADDR_RELOAD_LO: rdata_d = reload_q[7:0];
        `T2_ADDR_RELOAD_HI: rdata_d = reload_q[15:8];
        default:            rdata_d = `T2_BYTE_ZERO;
      endcase
    end
    irq_d = timer_irq_enable & (ctrl_d[`T2_BIT_OVF] | ctrl_d[`T2_BIT_EXT]);
    rxt_d = ctrl_q[`T2_BIT_RXSEL] ? ovf : timer_one_overflow;
    txt_d = ctrl_q[`T2_BIT_TXSEL] ? ovf : timer_one_overflow;
  end

  // registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q   <= `T2_CONTROL_RESET;
      count_q  <= `T2_WORD_RESET;
      reload_q <= `T2_WORD_RESET;
      rdata_q  <= `T2_BYTE_ZERO;
      irq_q    <= 1'b0;
      rxt_q    <= 1'b0;
      txt_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      reload_q <= reload_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
      rxt_q    <= rxt_d;
      txt_q    <= txt_d;
    end
  end

  assign rdata        = rdata_q;
  assign timer_irq    = irq_q;
  assign rx_baud_tick = rxt_q;
  assign tx_baud_tick = txt_q;

  // assertions
  property p_hold;
    @(posedge clk) disable iff (!arst_n)
      (!ctrl_q[`T2_BIT_RUN] && !wr && !(ctrl_q[`T2_BIT_EXTEN] && trig_fall))
        |=> (count_q == $past(count_q));
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while stopped");

  property p_timer_inc;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_q[`T2_BIT_RUN] && !ctrl_q[`T2_BIT_CNTSEL] && !wr && !ctrl_q[`T2_BIT_EXTEN]
       && count_q != `T2_WORD_MAX) |=> (count_q == $past(count_q) + 16'h0001);
  endproperty
  a_timer_inc: assert property (p_timer_inc)
    else $error("timer did not increment");

  property p_cnt_idle;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_q[`T2_BIT_CNTSEL] && !cnt_fall && !wr && !ctrl_q[`T2_BIT_EXTEN])
        |=> (count_q == $past(count_q));
  endproperty
  a_cnt_idle: assert property (p_cnt_idle)
    else $error("counter moved without pin edge");

  property p_cnt_edge;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_q[`T2_BIT_RUN] && ctrl_q[`T2_BIT_CNTSEL] && cnt_fall && !wr
       && !ctrl_q[`T2_BIT_EXTEN] && count_q != `T2_WORD_MAX)
        |=> (count_q == $past(count_q) + 16'h0001);
  endproperty
  a_cnt_edge: assert property (p_cnt_edge)
    else $error("pin edge not counted");

  property p_reload;
    @(posedge clk) disable iff (!arst_n)
      (ovf && !wr && !(ctrl_q[`T2_BIT_EXTEN] && trig_fall)) |=> (count_q == $past(reload_q));
  endproperty
  a_reload: assert property (p_reload)
    else $error("no reload on overflow");

  // the trigger neither reloads nor captures while the timer feeds the serial port
  property p_trig_reload;
    @(posedge clk) disable iff (!arst_n)
      (trig_fall && ctrl_q[`T2_BIT_EXTEN] && !ctrl_q[`T2_BIT_CAPSEL] && !baud_mode && !wr)
        |=> (count_q == $past(reload_q));
  endproperty
  a_trig_reload: assert property (p_trig_reload)
    else $error("no reload on trigger");

  property p_capture;
    @(posedge clk) disable iff (!arst_n)
      (trig_fall && ctrl_q[`T2_BIT_EXTEN] && ctrl_q[`T2_BIT_CAPSEL] && !baud_mode && !wr)
        |=> (reload_q == $past(count_q));
  endproperty
  a_capture: assert property (p_capture)
    else $error("no capture on trigger");

  // irq is built from the flag's next value, so both are seen at the same edge
  property p_ext_flag;
    @(posedge clk) disable iff (!arst_n)
      (ctrl_q[`T2_BIT_EXTEN] && trig_fall)
        |=> (ctrl_q[`T2_BIT_EXT] && (timer_irq || !$past(timer_irq_enable)));
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("external flag or irq missing");

  property p_ovf_flag;
    @(posedge clk) disable iff (!arst_n)
      ($rose(ctrl_q[`T2_BIT_OVF]) && !$past(wr)) |-> ($past(ovf) && !$past(baud_mode));
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow flag set without cause");

  property p_baud;
    @(posedge clk) disable iff (!arst_n)
      ctrl_q[`T2_BIT_RXSEL] |=> (rx_baud_tick == $past(ovf));
  endproperty
  a_baud: assert property (p_baud)
    else $error("receive clock not from this timer");

  property p_baud_tx;
    @(posedge clk) disable iff (!arst_n)
      ctrl_q[`T2_BIT_TXSEL] |=> (tx_baud_tick == $past(ovf));
  endproperty
  a_baud_tx: assert property (p_baud_tx)
    else $error("transmit clock not from this timer");

  property p_reset_zero;
    @(posedge clk) $rose(arst_n) |-> (ctrl_q == `T2_CONTROL_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("control not zero after reset");
endmodule
`default_nettype wire

/* hdl/timer_two_defines.svh */
/*
  constants of the second general timer: register offsets, control bit
  positions, reset value. assumes inclusion by bare name.
*/
`ifndef TIMER_TWO_DEFINES_SVH
`define TIMER_TWO_DEFINES_SVH

// register offsets on the plain register port
`define T2_ADDR_CONTROL   4'h0
`define T2_ADDR_COUNT_LO  4'h1
`define T2_ADDR_COUNT_HI  4'h2
`define T2_ADDR_RELOAD_LO 4'h3
`define T2_ADDR_RELOAD_HI 4'h4
`define T2_ADDR_BITSET    4'h5
`define T2_ADDR_BITCLR    4'h6

// control bit positions
`define T2_BIT_OVF    7
`define T2_BIT_EXT    6
`define T2_BIT_RXSEL  5
`define T2_BIT_TXSEL  4
`define T2_BIT_EXTEN  3
`define T2_BIT_RUN    2
`define T2_BIT_CNTSEL 1
`define T2_BIT_CAPSEL 0

// reset values and counter maximum
`define T2_CONTROL_RESET 8'h00
`define T2_WORD_RESET    16'h0000
`define T2_WORD_MAX      16'hFFFF
`define T2_BYTE_ZERO     8'h00

`endif

/* hdl/timer_two_pkg.sv */
/*
  types of the second general timer.
  assumes nothing of its surroundings.
*/
`default_nettype none
package timer_two_pkg;
  // what the counter does this cycle
  typedef enum logic [1:0] {act_hold, act_inc, act_reload, act_capture} count_act_type;
endpackage
`default_nettype wire

/* hdl/pin_sync.sv */
/*
  two-flip-flop synchroniser for the external pins, followed by a falling
  edge detector fed from the second stage only.
  assumes pins asynchronous to clk.
*/
`default_nettype none
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // pin and result
  input  wire logic pin,
  output logic      level,
  output logic      fall
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  // next values; idle level high so no false edge at reset
  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level = sync_q;
  assign fall  = last_q & ~sync_q;
endmodule
`default_nettype wire

/* tb/pin_partner.sv */
/*
  far-side model: count pin, trigger pin and first timer overflow.
  assumes the bench calls its tasks; both pins idle high (pulled up).
*/
`default_nettype none
module pin_partner (
  // clock
  input  wire logic clk,
  // pins and first timer
  output var logic  count_pin,
  output var logic  trig_pin,
  output var logic  t1_ovf
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle levels from time zero
  initial begin
    count_pin = 1'b1;
    trig_pin  = 1'b1;
    t1_ovf    = 1'b0;
  end
  // low for 4 clocks, longer than the synchroniser can lose
  task automatic fall(input bit trig);
    @(posedge clk);
    if (trig) trig_pin <= 1'b0;
    else count_pin <= 1'b0;
    repeat (4) @(posedge clk);
    trig_pin  <= 1'b1;
    count_pin <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // one-cycle pulse on the shared clock
  task automatic t1_pulse();
    @(posedge clk);
    t1_ovf <= 1'b1;
    @(posedge clk);
    t1_ovf <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
  self-checking bench of the second general timer.
  assumes timer_two and pin_partner are compiled before it.
*/
`include "timer_two_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] a_ctl = `T2_ADDR_CONTROL;
  localparam logic [3:0] a_clr = `T2_ADDR_BITCLR;
  logic       clk, arst_n, wr, rd, irq_en, irq, rx_tick, tx_tick, cpin, tpin, t1;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int         fails, samples_checked, rx_n, tx_n;

  timer_two timer_two_inst (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin(cpin),
    .external_trigger_pin(tpin), .timer_one_overflow(t1), .timer_irq_enable(irq_en),
    .timer_irq(irq), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick));
  pin_partner pin_partner_inst (.clk(clk), .count_pin(cpin), .trig_pin(tpin), .t1_ovf(t1));

  // 100 ns clock
  always #50 clk = ~clk;
  // tally baud ticks handed to the serial port
  always @(posedge clk) begin
    if (rx_tick === 1'b1) rx_n++;
    if (tx_tick === 1'b1) tx_n++;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic set_word(input logic [3:0] a, input logic [15:0] w);
    wr_reg(a, w[7:0]);
    wr_reg(a + 4'h1, w[15:8]);
  endtask

  task automatic t_reset();
    rd_chk(a_ctl, 8'h00);
    rd_chk(`T2_ADDR_COUNT_LO, 8'h00);
    wr_reg(4'h7, 8'hFF);
    rd_chk(4'h7, 8'h00);
    rd_chk(a_ctl, 8'h00);
    $display("test reset done");
  endtask
  // 2 increments during the clearing strobe plus 9 idle cycles
  task automatic t_timer();
    set_word(`T2_ADDR_COUNT_LO, 16'h0000);
    wr_reg(`T2_ADDR_BITSET, 8'h04);
    repeat (9) @(posedge clk);
    wr_reg(a_clr, 8'h04);
    repeat (5) @(posedge clk);
    rd_chk(`T2_ADDR_COUNT_LO, 8'h0B);
    rd_chk(`T2_ADDR_COUNT_HI, 8'h00);
    $display("test timer done");
  endtask
  // clock cycles must not count here, only pin falls
  task automatic t_counter();
    set_word(`T2_ADDR_COUNT_LO, 16'h0000);
    wr_reg(a_ctl, 8'h06);
    repeat (3) pin_partner_inst.fall(1'b0);
    wr_reg(a_ctl, 8'h00);
    rd_chk(`T2_ADDR_COUNT_LO, 8'h03);
    $display("test counter done");
  endtask
  // overflow wraps to the reload word, then one more step
  task automatic t_overflow();
    set_word(`T2_ADDR_COUNT_LO, 16'hFFFF);
    set_word(`T2_ADDR_RELOAD_LO, 16'h0010);
    wr_reg(a_ctl, 8'h04);
    wr_reg(a_clr, 8'h04);
    #1 check({7'h00, irq}, 8'h01);
    rd_chk(a_ctl, 8'h80);
    rd_chk(`T2_ADDR_COUNT_LO, 8'h11);
    wr_reg(a_clr, 8'h80);
    rd_chk(a_ctl, 8'h00);
    check({7'h00, irq}, 8'h00);
    $display("test overflow done");
  endtask
  // capture select set but ignored in baud use: reload to zero, then 3 more ticks
  task automatic t_baud();
    set_word(`T2_ADDR_COUNT_LO, 16'hFFFF);
    set_word(`T2_ADDR_RELOAD_LO, 16'h0000);
    rx_n = 0;
    tx_n = 0;
    wr_reg(a_ctl, 8'h35);
    pin_partner_inst.t1_pulse();
    wr_reg(a_clr, 8'h04);
    repeat (3) @(posedge clk);
    rd_chk(a_ctl, 8'h31);
    rd_chk(`T2_ADDR_COUNT_LO, 8'h03);
    check(8'(rx_n), 8'h01);
    check(8'(tx_n), 8'h01);
    wr_reg(a_ctl, 8'h00);
    repeat (2) pin_partner_inst.t1_pulse();
    repeat (3) @(posedge clk);
    check(8'(rx_n), 8'h03);
    check(8'(tx_n), 8'h03);
    $display("test baud done");
  endtask
  task automatic t_trigger();
    wr_reg(a_ctl, 8'h08);
    pin_partner_inst.fall(1'b1);
    rd_chk(a_ctl, 8'h48);
    check({7'h00, irq}, 8'h01);
    rd_chk(`T2_ADDR_COUNT_LO, 8'h00);
    @(posedge clk);
    irq_en <= 1'b0;
    repeat (3) @(posedge clk);
    check({7'h00, irq}, 8'h00);
    wr_reg(a_clr, 8'h40);
    rd_chk(a_ctl, 8'h08);
    $display("test trigger done");
  endtask
  // stopped timer, capture mode: trigger copies the count, count holds
  task automatic t_capture();
    set_word(`T2_ADDR_COUNT_LO, 16'h1234);
    wr_reg(a_ctl, 8'h09);
    pin_partner_inst.fall(1'b1);
    rd_chk(`T2_ADDR_RELOAD_LO, 8'h34);
    rd_chk(`T2_ADDR_RELOAD_HI, 8'h12);
    rd_chk(`T2_ADDR_COUNT_LO, 8'h34);
    rd_chk(a_ctl, 8'h49);
    check({7'h00, irq}, 8'h00);
    wr_reg(a_ctl, 8'h00);
    $display("test capture done");
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // stimulus: reset for 6 cycles, then the tests
  initial begin
    clk    = 1'b0;
    arst_n = 1'b0;
    wr     = 1'b0;
    rd     = 1'b0;
    addr   = 4'h0;
    wdata  = 8'h00;
    irq_en = 1'b1;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_timer();
    t_counter();
    t_overflow();
    t_baud();
    t_trigger();
    t_capture();
    give_verdict();
  end
  // tests need under 200 cycles; cut a hang short
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
